// *** dmag_top.sv ***
// Data memory address generator with its register file
`timescale 1ns/1ps
`include "dmag_defines.svh"
module dmag_top (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [`DMAG_AW-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [`DMAG_AW-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic req_valid_i,
  input wire dmag_pkg::dmag_mode_t req_mode_i,
  input wire dmag_pkg::dmag_op_t req_op_i,
  input wire logic [11:0] req_operand_i,
  input wire logic [1:0] req_bit_i,
  input wire logic [7:0] req_sp_i,
  output logic addr_valid_o,
  output logic [11:0] addr_o,
  output logic [1:0] bit_sel_o,
  output logic pair_o,
  output logic ram_sel_o,
  output logic periph_sel_o,
  output logic refused_o
);
  dmag_regbus_if rb ();

  dmag_axi_slave u_axi (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .s_axi_awaddr_i(s_axi_awaddr_i),
    .s_axi_awvalid_i(s_axi_awvalid_i),
    .s_axi_awready_o(s_axi_awready_o),
    .s_axi_wdata_i(s_axi_wdata_i),
    .s_axi_wstrb_i(s_axi_wstrb_i),
    .s_axi_wvalid_i(s_axi_wvalid_i),
    .s_axi_wready_o(s_axi_wready_o),
    .s_axi_bresp_o(s_axi_bresp_o),
    .s_axi_bvalid_o(s_axi_bvalid_o),
    .s_axi_bready_i(s_axi_bready_i),
    .s_axi_araddr_i(s_axi_araddr_i),
    .s_axi_arvalid_i(s_axi_arvalid_i),
    .s_axi_arready_o(s_axi_arready_o),
    .s_axi_rdata_o(s_axi_rdata_o),
    .s_axi_rresp_o(s_axi_rresp_o),
    .s_axi_rvalid_o(s_axi_rvalid_o),
    .s_axi_rready_i(s_axi_rready_i),
    .rb(rb.bus)
  );

  logic bank_enable_flag;
  logic stack_bank_choice;
  logic [3:0] bank_select_reg;
  logic [3:0] ptr_l;
  logic [3:0] ptr_h;
  logic [3:0] ptr_d;
  logic [3:0] ptr_e;
  logic bank_refused;
  logic req_refused;
  logic [31:0] ctrl_word;
  logic [31:0] ptr_word;
  logic [31:0] stat_word;
  logic [11:0] next_addr;
  logic [1:0] next_bit;
  logic next_pair;
  logic next_ok;
  logic [3:0] dir_bank;
  logic [3:0] and_bank;

  function automatic logic reg_is(input logic [`DMAG_AW-1:0] a,
                                  input logic [`DMAG_AW-1:0] ofs);
    reg_is = (a[`DMAG_AW-1:2] == ofs[`DMAG_AW-1:2]);
  endfunction : reg_is

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [31:0] m);
    merge = (old & ~m) | (wd & m);
  endfunction : merge

  function automatic logic bank_legal(input logic [3:0] b);
    bank_legal = (b == `DMAG_BANK_RAM0) || (b == `DMAG_BANK_RAM1) ||
                 (b == `DMAG_BANK_PERIPH);
  endfunction : bank_legal

  dmag_bank_resolve u_bank (
    .operand_i(req_operand_i[7:0]),
    .bank_enable_flag_i(bank_enable_flag),
    .bank_select_reg_i(bank_select_reg),
    .dir_bank_o(dir_bank),
    .and_bank_o(and_bank)
  );

  always_comb begin
    ctrl_word = 32'h0;
    ctrl_word[`DMAG_CTRL_BEF] = bank_enable_flag;
    ctrl_word[`DMAG_CTRL_STKB] = stack_bank_choice;
    ptr_word = 32'h0;
    ptr_word[`DMAG_PTR_L] = ptr_l;
    ptr_word[`DMAG_PTR_H] = ptr_h;
    ptr_word[`DMAG_PTR_E] = ptr_e;
    ptr_word[`DMAG_PTR_D] = ptr_d;
    stat_word = 32'h0;
    stat_word[`DMAG_STAT_BANKREF] = bank_refused;
    stat_word[`DMAG_STAT_REQREF] = req_refused;
    stat_word[`DMAG_STAT_ADDR] = addr_o;
    stat_word[`DMAG_STAT_BIT] = bit_sel_o;
  end

  wire rd_ctrl = reg_is(rb.rd_addr, `DMAG_CTRL_OFS);
  wire rd_bsel = reg_is(rb.rd_addr, `DMAG_BSEL_OFS);
  wire rd_ptr = reg_is(rb.rd_addr, `DMAG_PTR_OFS);
  wire rd_stat = reg_is(rb.rd_addr, `DMAG_STAT_OFS);
  assign rb.rd_ok = rd_ctrl | rd_bsel | rd_ptr | rd_stat;
  assign rb.rd_data = rd_ctrl ? ctrl_word :
                      rd_bsel ? {28'h0, bank_select_reg} :
                      rd_ptr ? ptr_word :
                      rd_stat ? stat_word : 32'h0;

  wire wr_ctrl = rb.wr_en & reg_is(rb.wr_addr, `DMAG_CTRL_OFS);
  wire wr_bsel = rb.wr_en & reg_is(rb.wr_addr, `DMAG_BSEL_OFS);
  wire wr_ptr = rb.wr_en & reg_is(rb.wr_addr, `DMAG_PTR_OFS);
  wire wr_stat = rb.wr_en & reg_is(rb.wr_addr, `DMAG_STAT_OFS);
  assign rb.wr_ok = reg_is(rb.wr_addr, `DMAG_CTRL_OFS) |
                    reg_is(rb.wr_addr, `DMAG_BSEL_OFS) |
                    reg_is(rb.wr_addr, `DMAG_PTR_OFS) |
                    reg_is(rb.wr_addr, `DMAG_STAT_OFS);
  wire [31:0] ctrl_new = merge(ctrl_word, rb.wr_data, rb.wr_mask);
  wire [31:0] bsel_new = merge({28'h0, bank_select_reg}, rb.wr_data,
                               rb.wr_mask);
  wire [31:0] ptr_new = merge(ptr_word, rb.wr_data, rb.wr_mask);
  wire [31:0] stat_clr = rb.wr_data & rb.wr_mask & {32{wr_stat}};
  wire bsel_ok = bank_legal(bsel_new[`DMAG_BSEL_FLD]);

  wire bit_op_ok = (req_op_i == dmag_pkg::BIT_SET_OP) ||
                   (req_op_i == dmag_pkg::BIT_CLEAR_OP) ||
                   (req_op_i == dmag_pkg::SKIP_IF_TRUE_OP) ||
                   (req_op_i == dmag_pkg::SKIP_IF_FALSE_OP);
  wire byte_op_ok = (req_op_i == dmag_pkg::TRANSFER_OP) ||
                    (req_op_i == dmag_pkg::SWAP_OP) ||
                    (req_op_i == dmag_pkg::PORT_READ_OP) ||
                    (req_op_i == dmag_pkg::PORT_WRITE_OP);
  wire nib_op_ok = byte_op_ok ||
                   (req_op_i == dmag_pkg::INCREMENT_SKIP_OP);
  wire [11:0] dir_addr = {dir_bank, req_operand_i[7:0]};
  wire [7:0] fix_page = req_operand_i[11:4];
  wire take = req_valid_i & next_ok;
  wire step_inc = take & (req_mode_i == dmag_pkg::MODE_NIB_FIRST_INC);
  wire step_dec = take & (req_mode_i == dmag_pkg::MODE_NIB_FIRST_DEC);

  always_comb begin
    next_addr = dir_addr;
    next_bit = req_bit_i;
    next_pair = 1'b0;
    next_ok = 1'b1;
    unique case (req_mode_i)
      dmag_pkg::MODE_BIT_DIR: next_ok = bit_op_ok;
      dmag_pkg::MODE_NIB_DIR: next_ok = nib_op_ok;
      dmag_pkg::MODE_BYTE_DIR: begin
        next_ok = byte_op_ok & ~req_operand_i[0];
        next_pair = 1'b1;
      end
      dmag_pkg::MODE_NIB_FIRST, dmag_pkg::MODE_NIB_FIRST_INC,
      dmag_pkg::MODE_NIB_FIRST_DEC: begin
        next_addr = {and_bank, ptr_h, ptr_l};
      end
      dmag_pkg::MODE_NIB_SECOND: begin
        next_addr = {`DMAG_BANK_RAM0, ptr_d, ptr_e};
      end
      dmag_pkg::MODE_NIB_THIRD: begin
        next_addr = {`DMAG_BANK_RAM0, ptr_d, ptr_l};
      end
      dmag_pkg::MODE_BYTE_FIRST: begin
        next_addr = {and_bank, ptr_h, ptr_l[3:1], 1'b0};
        next_pair = 1'b1;
      end
      dmag_pkg::MODE_FIX_BIT: begin
        next_addr = req_operand_i;
        next_ok = (fix_page == `DMAG_FIX_INTR) ||
                  (fix_page == `DMAG_FIX_PORT);
      end
      dmag_pkg::MODE_PTR_BIT: begin
        next_addr = {req_operand_i[11:2], ptr_l[3:2]};
        next_bit = ptr_l[1:0];
        next_ok = (req_operand_i[11:6] == `DMAG_PMEM_TOP);
      end
      dmag_pkg::MODE_PAGE_BIT: begin
        next_addr = {and_bank, ptr_h, req_operand_i[3:0]};
      end
      dmag_pkg::MODE_STACK: begin
        // Only banks 0 and 1 can hold the stack, so the top bits stay zero
        next_addr = {3'h0, stack_bank_choice, req_sp_i};
      end
      default: next_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bank_enable_flag <= 1'b0;
      stack_bank_choice <= 1'b0;
      bank_select_reg <= `DMAG_NIB_RST;
      bank_refused <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        bank_enable_flag <= ctrl_new[`DMAG_CTRL_BEF];
        stack_bank_choice <= ctrl_new[`DMAG_CTRL_STKB];
      end
      // Illegal bank codes are dropped so the register never holds one
      if (wr_bsel && bsel_ok) begin
        bank_select_reg <= bsel_new[`DMAG_BSEL_FLD];
      end
      bank_refused <= (wr_bsel & ~bsel_ok) |
        (bank_refused & ~stat_clr[`DMAG_STAT_BANKREF]);
    end
  end

  // Pipeline steps win over a same-cycle software write of the low nibble
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ptr_l <= `DMAG_NIB_RST;
      ptr_h <= `DMAG_NIB_RST;
      ptr_d <= `DMAG_NIB_RST;
      ptr_e <= `DMAG_NIB_RST;
    end else begin
      if (step_inc) ptr_l <= ptr_l + 4'h1;
      else if (step_dec) ptr_l <= ptr_l - 4'h1;
      else if (wr_ptr) ptr_l <= ptr_new[`DMAG_PTR_L];
      if (wr_ptr) begin
        ptr_h <= ptr_new[`DMAG_PTR_H];
        ptr_d <= ptr_new[`DMAG_PTR_D];
        ptr_e <= ptr_new[`DMAG_PTR_E];
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      addr_valid_o <= 1'b0;
      addr_o <= 12'h000;
      bit_sel_o <= 2'h0;
      pair_o <= 1'b0;
      ram_sel_o <= 1'b0;
      periph_sel_o <= 1'b0;
      refused_o <= 1'b0;
      req_refused <= 1'b0;
    end else begin
      addr_valid_o <= take;
      refused_o <= req_valid_i & ~next_ok;
      req_refused <= (req_valid_i & ~next_ok) |
        (req_refused & ~stat_clr[`DMAG_STAT_REQREF]);
      if (take) begin
        addr_o <= next_addr;
        bit_sel_o <= next_bit;
        pair_o <= next_pair;
        ram_sel_o <= (next_addr <= `DMAG_RAM_LAST);
        periph_sel_o <= (next_addr >= `DMAG_PERIPH_BASE);
      end
    end
  end

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_dir_take;
    take && !bank_enable_flag && (req_mode_i == dmag_pkg::MODE_BIT_DIR ||
      req_mode_i == dmag_pkg::MODE_NIB_DIR ||
      req_mode_i == dmag_pkg::MODE_BYTE_DIR);
  endsequence
  sequence s_step;
    (step_inc || step_dec) && !wr_ptr;
  endsequence

  property p_dir_low;
    s_dir_take ##0 !req_operand_i[7] |=> addr_o[11:8] == 4'h0;
  endproperty
  a_dir_low: assert property (p_dir_low)
    else $error("direct low operand not in bank 0");
  property p_dir_high;
    s_dir_take ##0 req_operand_i[7] |=> addr_o[11:8] == 4'hF;
  endproperty
  a_dir_high: assert property (p_dir_high)
    else $error("direct high operand not in bank 15");
  property p_dir_sel;
    take && bank_enable_flag && req_mode_i == dmag_pkg::MODE_NIB_DIR
      |=> addr_o == {$past(bank_select_reg), $past(req_operand_i[7:0])};
  endproperty
  a_dir_sel: assert property (p_dir_sel)
    else $error("enabled direct bank differs from select register");
  property p_bit_op;
    req_valid_i && req_mode_i == dmag_pkg::MODE_BIT_DIR &&
      req_op_i == dmag_pkg::TRANSFER_OP |=> refused_o && !addr_valid_o;
  endproperty
  a_bit_op: assert property (p_bit_op)
    else $error("direct bit mode accepted a non-bit operation");
  property p_first_bank;
    take && req_mode_i == dmag_pkg::MODE_NIB_FIRST
      |=> addr_o[11:8] == ($past(bank_select_reg) &
                           {4{$past(bank_enable_flag)}});
  endproperty
  a_first_bank: assert property (p_first_bank)
    else $error("first pointer bank is not enable AND select");
  property p_step;
    s_step |=> ptr_h == $past(ptr_h) && ptr_l ==
      ($past(step_inc) ? $past(ptr_l) + 4'h1 : $past(ptr_l) - 4'h1);
  endproperty
  a_step: assert property (p_step)
    else $error("low pointer step wrong or high pointer moved");
  property p_step_after;
    step_inc |=> addr_o[3:0] == $past(ptr_l);
  endproperty
  a_step_after: assert property (p_step_after)
    else $error("address did not use the pointer before its step");
  property p_bank0_ptr;
    take && (req_mode_i == dmag_pkg::MODE_NIB_SECOND ||
      req_mode_i == dmag_pkg::MODE_NIB_THIRD) |=> addr_o[11:8] == 4'h0;
  endproperty
  a_bank0_ptr: assert property (p_bank0_ptr)
    else $error("second or third pointer left bank 0");
  property p_fix;
    addr_valid_o && $past(req_mode_i) == dmag_pkg::MODE_FIX_BIT
      |-> addr_o[11:4] == 8'hFB || addr_o[11:4] == 8'hFF;
  endproperty
  a_fix: assert property (p_fix)
    else $error("fixed-area bit outside its two ranges");
  property p_stack;
    take && req_mode_i == dmag_pkg::MODE_STACK
      |=> addr_o == {3'h0, $past(stack_bank_choice), $past(req_sp_i)};
  endproperty
  a_stack: assert property (p_stack)
    else $error("stack address wrong");
  property p_bsel;
    bank_select_reg == 4'h0 || bank_select_reg == 4'h1 ||
      bank_select_reg == 4'hF;
  endproperty
  a_bsel: assert property (p_bsel)
    else $error("bank select register holds an illegal bank");
  property p_space;
    addr_valid_o |-> ram_sel_o == (addr_o <= 12'h1FF) &&
      periph_sel_o == (addr_o >= 12'hF80);
  endproperty
  a_space: assert property (p_space)
    else $error("space select disagrees with address");
endmodule : dmag_top

// *** dmag_defines.svh ***
// Register map, field positions and address-space constants
`ifndef DMAG_DEFINES_SVH
`define DMAG_DEFINES_SVH
`define DMAG_AW 8
`define DMAG_CTRL_OFS 8'h00
`define DMAG_BSEL_OFS 8'h04
`define DMAG_PTR_OFS 8'h08
`define DMAG_STAT_OFS 8'h0C
`define DMAG_CTRL_BEF 0
`define DMAG_CTRL_STKB 1
`define DMAG_BSEL_FLD 3:0
`define DMAG_PTR_L 3:0
`define DMAG_PTR_H 7:4
`define DMAG_PTR_E 11:8
`define DMAG_PTR_D 15:12
`define DMAG_STAT_BANKREF 0
`define DMAG_STAT_REQREF 1
`define DMAG_STAT_ADDR 15:4
`define DMAG_STAT_BIT 17:16
`define DMAG_NIB_RST 4'h0
`define DMAG_DIR_HI_BIT 7
`define DMAG_BANK_RAM0 4'h0
`define DMAG_BANK_RAM1 4'h1
`define DMAG_BANK_PERIPH 4'hF
`define DMAG_RAM_LAST 12'h1FF
`define DMAG_PERIPH_BASE 12'hF80
`define DMAG_FIX_INTR 8'hFB
`define DMAG_FIX_PORT 8'hFF
`define DMAG_PMEM_TOP 6'h3F
`define DMAG_RESP_OKAY 2'h0
`define DMAG_RESP_SLVERR 2'h2
`endif

// *** dmag_pkg.sv ***
// Types shared by the address generator files
package dmag_pkg;
  typedef enum logic [3:0] {
    MODE_BIT_DIR, MODE_NIB_DIR, MODE_BYTE_DIR,
    MODE_NIB_FIRST, MODE_NIB_FIRST_INC, MODE_NIB_FIRST_DEC,
    MODE_NIB_SECOND, MODE_NIB_THIRD, MODE_BYTE_FIRST,
    MODE_FIX_BIT, MODE_PTR_BIT, MODE_PAGE_BIT, MODE_STACK
  } dmag_mode_t;
  typedef enum logic [3:0] {
    BIT_SET_OP, BIT_CLEAR_OP, SKIP_IF_TRUE_OP, SKIP_IF_FALSE_OP,
    TRANSFER_OP, SWAP_OP, INCREMENT_SKIP_OP, PORT_READ_OP,
    PORT_WRITE_OP, OTHER_OP
  } dmag_op_t;
endpackage : dmag_pkg

// *** dmag_regbus_if.sv ***
// Internal register access carrier between bus slave and register file
`timescale 1ns/1ps
`include "dmag_defines.svh"
interface dmag_regbus_if;
  logic wr_en;
  logic [`DMAG_AW-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [31:0] wr_mask;
  logic wr_ok;
  logic [`DMAG_AW-1:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;
  modport bus (output wr_en, wr_addr, wr_data, wr_mask, rd_addr,
               input wr_ok, rd_data, rd_ok);
  modport regs (input wr_en, wr_addr, wr_data, wr_mask, rd_addr,
                output wr_ok, rd_data, rd_ok);
endinterface : dmag_regbus_if

// *** dmag_bank_resolve.sv ***
// Bank resolution for direct and first-pointer addressing
`timescale 1ns/1ps
`include "dmag_defines.svh"
module dmag_bank_resolve (
  input wire logic [7:0] operand_i,
  input wire logic bank_enable_flag_i,
  input wire logic [3:0] bank_select_reg_i,
  output logic [3:0] dir_bank_o,
  output logic [3:0] and_bank_o
);
  wire [3:0] fixed_bank = operand_i[`DMAG_DIR_HI_BIT] ?
    `DMAG_BANK_PERIPH : `DMAG_BANK_RAM0;
  // Enabled flag hands the choice to the select register
  assign dir_bank_o = bank_enable_flag_i ? bank_select_reg_i :
    fixed_bank;
  assign and_bank_o = bank_select_reg_i &
    {4{bank_enable_flag_i}};
endmodule : dmag_bank_resolve

// *** dmag_axi_slave.sv ***
// AXI4-Lite slave front end feeding the register carrier
`timescale 1ns/1ps
`include "dmag_defines.svh"
module dmag_axi_slave (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [`DMAG_AW-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [`DMAG_AW-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  dmag_regbus_if.bus rb
);
  logic aw_full;
  logic w_full;
  logic [`DMAG_AW-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction : strb_mask

  wire aw_take = s_axi_awvalid_i & s_axi_awready_o;
  wire w_take = s_axi_wvalid_i & s_axi_wready_o;
  // Write waits for both halves and for the previous response to drain
  wire wr_fire = aw_full & w_full & ~s_axi_bvalid_o;
  wire next_aw_full = (aw_full & ~wr_fire) | aw_take;
  wire next_w_full = (w_full & ~wr_fire) | w_take;
  wire ar_take = s_axi_arvalid_i & s_axi_arready_o;
  wire next_rvalid = ar_take | (s_axi_rvalid_o & ~s_axi_rready_i);

  assign rb.wr_en = wr_fire;
  assign rb.wr_addr = aw_addr;
  assign rb.wr_data = w_data;
  assign rb.wr_mask = strb_mask(w_strb);
  assign rb.rd_addr = s_axi_araddr_i;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o <= 1'b0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `DMAG_RESP_OKAY;
    end else begin
      aw_full <= next_aw_full;
      w_full <= next_w_full;
      s_axi_awready_o <= ~next_aw_full;
      s_axi_wready_o <= ~next_w_full;
      if (aw_take) aw_addr <= s_axi_awaddr_i;
      if (w_take) begin
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
      end
      if (wr_fire) begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= rb.wr_ok ? `DMAG_RESP_OKAY : `DMAG_RESP_SLVERR;
      end else if (s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0;
      s_axi_rresp_o <= `DMAG_RESP_OKAY;
    end else begin
      s_axi_arready_o <= ~next_rvalid;
      s_axi_rvalid_o <= next_rvalid;
      if (ar_take) begin
        s_axi_rdata_o <= rb.rd_ok ? rb.rd_data : 32'h0;
        s_axi_rresp_o <= rb.rd_ok ? `DMAG_RESP_OKAY : `DMAG_RESP_SLVERR;
      end
    end
  end
endmodule : dmag_axi_slave

// *** dmag_cpu_model.sv ***
// CPU sequencer stand-in that issues address requests
`timescale 1ns/1ps
module dmag_cpu_model (
  input wire logic clk_sys_i,
  output logic req_valid_o = 1'h0,
  output dmag_pkg::dmag_mode_t req_mode_o = dmag_pkg::MODE_STACK,
  output dmag_pkg::dmag_op_t req_op_o = dmag_pkg::OTHER_OP,
  output logic [11:0] req_operand_o = 12'h000,
  output logic [1:0] req_bit_o = 2'h0,
  output logic [7:0] req_sp_o = 8'h00
);
  task send(input dmag_pkg::dmag_mode_t m, input dmag_pkg::dmag_op_t o,
            input logic [11:0] a, input logic [1:0] b);
    @(posedge clk_sys_i);
    req_valid_o <= 1'h1;
    req_mode_o <= m;
    req_op_o <= o;
    req_operand_o <= a;
    req_bit_o <= b;
    req_sp_o <= a[7:0];
    @(posedge clk_sys_i);
    req_valid_o <= 1'h0;
    // Stale qualifiers must not pass for held ones
    req_operand_o <= ~a;
    req_sp_o <= ~a[7:0];
    req_bit_o <= ~b;
  endtask : send
endmodule : dmag_cpu_model

// *** dmag_tb.sv ***
// Self-checking bench for the address generator
`timescale 1ns/1ps
`include "dmag_defines.svh"
module tb;
  logic clk_sys_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic [7:0] s_axi_awaddr_i = 8'h00;
  logic [7:0] s_axi_araddr_i = 8'h00;
  logic [31:0] s_axi_wdata_i = 32'h0;
  logic [3:0] s_axi_wstrb_i = 4'hF;
  logic s_axi_awvalid_i = 1'h0, s_axi_wvalid_i = 1'h0;
  logic s_axi_bready_i = 1'h0, s_axi_arvalid_i = 1'h0;
  logic s_axi_rready_i = 1'h0;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
  logic s_axi_rvalid_o, addr_valid_o, pair_o, ram_sel_o, periph_sel_o;
  logic refused_o, req_valid_i;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, bit_sel_o, req_bit_i;
  logic [31:0] s_axi_rdata_o;
  logic [11:0] addr_o, req_operand_i;
  logic [7:0] req_sp_i;
  dmag_pkg::dmag_mode_t req_mode_i;
  dmag_pkg::dmag_op_t req_op_i;
  int n_errors = 0;
  int compares = 0;
  dmag_top dut_u (.*);
  dmag_cpu_model cpu_u (
    .clk_sys_i(clk_sys_i),
    .req_valid_o(req_valid_i),
    .req_mode_o(req_mode_i),
    .req_op_o(req_op_i),
    .req_operand_o(req_operand_i),
    .req_bit_o(req_bit_i),
    .req_sp_o(req_sp_i)
  );
  initial begin
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'h1;
    s_axi_wvalid_i <= 1'h1;
    s_axi_bready_i <= 1'h1;
    do begin
      @(posedge clk_sys_i);
      n++;
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'h0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'h0;
    end while (s_axi_bvalid_o !== 1'h1 && n < 50);
    s_axi_bready_i <= 1'h0;
    // Unmapped write answers with an error response
    cmp({s_axi_bvalid_o, s_axi_bresp_o},
        {1'h1, a > 8'h0C ? `DMAG_RESP_SLVERR : `DMAG_RESP_OKAY});
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] ed);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'h1;
    s_axi_rready_i <= 1'h1;
    do begin
      @(posedge clk_sys_i);
      n++;
      if (s_axi_arready_o) s_axi_arvalid_i <= 1'h0;
    end while (s_axi_rvalid_o !== 1'h1 && n < 50);
    s_axi_rready_i <= 1'h0;
    cmp(s_axi_rdata_o, ed);
    cmp({s_axi_rvalid_o, s_axi_rresp_o},
        {1'h1, a > 8'h0C ? `DMAG_RESP_SLVERR : `DMAG_RESP_OKAY});
  endtask : rd
  task rq(input dmag_pkg::dmag_mode_t m, input dmag_pkg::dmag_op_t o,
          input logic [11:0] a, input logic [1:0] b, input logic ok,
          input logic [11:0] ea);
    logic bm, pe;
    logic [1:0] bs;
    bm = m == dmag_pkg::MODE_BIT_DIR || m >= dmag_pkg::MODE_FIX_BIT;
    bm = bm && m != dmag_pkg::MODE_STACK;
    pe = m == dmag_pkg::MODE_BYTE_DIR || m == dmag_pkg::MODE_BYTE_FIRST;
    cpu_u.send(m, o, a, b);
    #1;
    bs = bm ? bit_sel_o : 2'h0;
    if (!ok) cmp({addr_valid_o, refused_o}, 2'h1);
    else cmp({addr_valid_o, refused_o, pair_o, ram_sel_o, periph_sel_o,
              bs, addr_o}, {2'h2, pe, ea <= `DMAG_RAM_LAST,
              ea >= `DMAG_PERIPH_BASE, bm ? b : 2'h0, ea});
  endtask : rq
  task stop_test;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test
  initial begin
    #2000000;
    n_errors++;
    stop_test;
  end
  initial begin : main
    dmag_pkg::dmag_op_t op;
    repeat (20) @(posedge clk_sys_i);
    rst_n_i <= 1'h1;
    repeat (3) @(posedge clk_sys_i);
    for (int i = 0; i < 20; i += 4) rd(i[7:0], 32'h0);
    wr(8'h10, 32'h1);
    // Every operation code against the bit and nibble direct modes
    for (int i = 0; i < 10; i++) begin
      op = dmag_pkg::dmag_op_t'(i);
      rq(dmag_pkg::MODE_BIT_DIR, op, 12'h03F, 2'h1,
         op <= dmag_pkg::SKIP_IF_FALSE_OP, 12'h03F);
      rq(dmag_pkg::MODE_NIB_DIR, op, 12'h07F, 2'h0,
         op >= dmag_pkg::TRANSFER_OP && op <= dmag_pkg::PORT_WRITE_OP,
         12'h07F);
    end
    rq(dmag_pkg::dmag_mode_t'(4'hF), op, 12'h0, 2'h0, 1'h0, 12'h0);
    wr(8'h04, 32'h1);
    wr(8'h04, 32'h5);
    rd(8'h04, 32'h1);
    rq(dmag_pkg::MODE_BIT_DIR, dmag_pkg::BIT_SET_OP, 12'h087, 2'h2, 1'h1,
       12'hF87);
    rd(8'h0C, 32'h0002_F873);
    wr(8'h0C, 32'h3);
    rd(8'h0C, 32'h0002_F870);
    rq(dmag_pkg::MODE_NIB_DIR, dmag_pkg::SWAP_OP, 12'h080, 2'h0, 1'h1,
       12'hF80);
    rq(dmag_pkg::MODE_BYTE_DIR, dmag_pkg::SWAP_OP, 12'h021, 2'h0, 1'h0,
       12'h0);
    wr(8'h00, 32'h1);
    rq(dmag_pkg::MODE_NIB_DIR, dmag_pkg::TRANSFER_OP, 12'h03F, 2'h0, 1'h1,
       12'h13F);
    rq(dmag_pkg::MODE_BYTE_DIR, dmag_pkg::TRANSFER_OP, 12'h0FE, 2'h0, 1'h1,
       12'h1FE);
    wr(8'h08, 32'h5A27);
    rq(dmag_pkg::MODE_NIB_FIRST_INC, op, 12'h0, 2'h0, 1'h1, 12'h127);
    rq(dmag_pkg::MODE_NIB_FIRST_DEC, op, 12'h0, 2'h0, 1'h1, 12'h128);
    rq(dmag_pkg::MODE_NIB_FIRST, op, 12'h0, 2'h0, 1'h1, 12'h127);
    rq(dmag_pkg::MODE_NIB_SECOND, op, 12'h0, 2'h0, 1'h1, 12'h05A);
    rq(dmag_pkg::MODE_NIB_THIRD, op, 12'h0, 2'h0, 1'h1, 12'h057);
    rq(dmag_pkg::MODE_BYTE_FIRST, op, 12'h0, 2'h0, 1'h1, 12'h126);
    rq(dmag_pkg::MODE_PAGE_BIT, op, 12'h009, 2'h3, 1'h1, 12'h129);
    rd(8'h08, 32'h5A27);
    wr(8'h00, 32'h0);
    rq(dmag_pkg::MODE_NIB_FIRST, op, 12'h0, 2'h0, 1'h1, 12'h027);
    wr(8'h08, 32'h5A2F);
    rq(dmag_pkg::MODE_NIB_FIRST_INC, op, 12'h0, 2'h0, 1'h1, 12'h02F);
    rd(8'h08, 32'h5A20);
    rq(dmag_pkg::MODE_NIB_FIRST_DEC, op, 12'h0, 2'h0, 1'h1, 12'h020);
    rd(8'h08, 32'h5A2F);
    rq(dmag_pkg::MODE_PTR_BIT, op, 12'hFC4, 2'h3, 1'h1, 12'hFC7);
    rq(dmag_pkg::MODE_PTR_BIT, op, 12'hF84, 2'h3, 1'h0, 12'h0);
    rq(dmag_pkg::MODE_FIX_BIT, op, 12'hFB0, 2'h1, 1'h1, 12'hFB0);
    rq(dmag_pkg::MODE_FIX_BIT, op, 12'hFFF, 2'h2, 1'h1, 12'hFFF);
    rq(dmag_pkg::MODE_FIX_BIT, op, 12'hFAF, 2'h1, 1'h0, 12'h0);
    rq(dmag_pkg::MODE_FIX_BIT, op, 12'hFC0, 2'h1, 1'h0, 12'h0);
    wr(8'h00, 32'h2);
    rq(dmag_pkg::MODE_STACK, op, 12'h022, 2'h0, 1'h1, 12'h122);
    wr(8'h00, 32'h0);
    rq(dmag_pkg::MODE_STACK, op, 12'h022, 2'h0, 1'h1, 12'h022);
    stop_test;
  end
endmodule : tb
